// ---- include/csds_pkg.sv ----
// constants, field layouts and types of the clock source and divider system
package csds_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PLL    = 8'h04;
    localparam logic [7:0] OFS_STAT   = 8'h08;
    localparam logic [7:0] OFS_FTC    = 8'h0c;
    localparam logic [7:0] OFS_BUSDIV = 8'h10;
    localparam logic [7:0] OFS_DIV0   = 8'h20;
    // writable bits of each register
    localparam logic [31:0] MSK_CTRL   = 32'h00007fff;
    localparam logic [31:0] MSK_PLL    = 32'h00003f3f;
    localparam logic [31:0] MSK_FTC    = 32'h0000001f;
    localparam logic [31:0] MSK_BUSDIV = 32'h000fffff;
    localparam logic [31:0] MSK_DIV    = 32'h0007ffff;
    // reset values
    localparam logic [31:0] RST_CTRL   = 32'h00000000;
    localparam logic [31:0] RST_PLL    = 32'h00000100;
    localparam logic [31:0] RST_FTC    = 32'h0000001f;
    localparam logic [31:0] RST_BUSDIV = 32'h00020002;
    localparam logic [31:0] RST_DIV    = 32'h00000002;
    // status field positions
    localparam int STAT_FTC_LSB  = 16;
    localparam int STAT_LOCK_BIT = 24;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOCK_TIME_NS  = 250000;
    localparam int LOCK_CYCLES   = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WATCH_SEC_TICKS = 32768;
    localparam int THIRD_DIV     = 3;
    // source numbers of the eight-input divider multiplexer
    localparam int SRC_N = 8;
    // reference selection of doubler and pll: 0 main osc, 1 crystal, 2 interconnect, 3 off
    typedef enum logic [1:0] {
        PLL_OFF = 2'b00,
        PLL_ACQ = 2'b01,
        PLL_LCK = 2'b11
    } csds_pll_e;
    typedef struct packed {
        logic [15:0] rsvd;
        logic        ctc_rst;
        logic [3:0]  ctc_tap;
        logic        ctc_en;
        logic        ftc_en;
        logic        watch_lp;
        logic        master_lp;
        logic        pll_en;
        logic [1:0]  pll_ref;
        logic [1:0]  dbl_src;
        logic [1:0]  imo_freq;
    } csds_ctrl_s;
    typedef struct packed {
        logic [17:0] rsvd;
        logic [5:0]  fb;
        logic [1:0]  rsvd2;
        logic [5:0]  ind;
    } csds_pll_s;
    typedef struct packed {
        logic [12:0] rsvd;
        logic [2:0]  src;
        logic [15:0] div;
    } csds_div_s;
endpackage

// ---- src/csds_top.sv ----
// clock sources, tick counters and divider tree with avalon register slave
`timescale 1ns/100ps
//
// Overview of operation
// - eight 16-bit digital system clock dividers
// - four 16-bit analog system clock dividers
// - 16-bit divider makes the bus clock from the master clock
// - 4-bit divider makes the processor clock
// - each digital and analog divider picks its own source
// - main oscillator frequency selectable among 3, 6, 12, 24 MHz
// - doubler gives twice its input, input from main osc, crystal or interconnect
// - pll output 24 to 50 MHz, reference from main osc, crystal or interconnect
// - pll input and feedback dividers give 4032 ratios
// - pll locks within 250 us and sets a readable lock bit
// - lock indication available as a routable signal
// - low-speed oscillator supplies 1, 33 and 100 kHz clocks
// - central tick counter is a free-running 13-bit count of the 1 kHz clock
// - central tick counter stops in hibernate and during debug halt
// - central tick counter raises periodic events and wakes the system
// - software can reset the central tick counter
// - fast tick counter: 5-bit, 100 kHz, programmable terminal count, auto restart
// - fast tick counter optionally raises an event at terminal count
// - 33 kHz clock is the 100 kHz clock divided by three
// - watch crystal gives a once-per-second event for the real-time clock
// - watch crystal has two selectable power modes
// - 100 kHz clock selectable as low-power master clock
// - divider: 8-input mux, divide by two or more, half duty for even divisors, deglitched
// - processor clock divider takes the bus clock as input

// ****************************************************************
// divider cell
// ****************************************************************
module csds_clkdiv #(
    parameter int W = 16
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] div_in,
    output logic              clk_out,
    output logic              rise_out
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] div_q;
    wire  [W-1:0] div_eff = (div_in < W'(2)) ? W'(2) : div_in;
    wire          wrap    = tick_in && (cnt_q == div_q - W'(1));
    wire  [W-1:0] cnt_nx  = wrap ? '0 : cnt_q + W'(1);

    // new divisor taken only at period end so no runt pulse
    // deglitched division, half duty for even divisors
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q    <= '0;
            div_q    <= W'(2);
            clk_out  <= 1'b0;
            rise_out <= 1'b0;
        end else begin
            rise_out <= wrap;
            if (tick_in) begin
                cnt_q   <= cnt_nx;
                clk_out <= wrap | (cnt_nx < (div_q >> 1));
            end
            if (wrap) begin
                div_q <= div_eff;
            end
        end
    end
endmodule

// ****************************************************************
// top level
// ****************************************************************
module csds_top
    import csds_pkg::*;
#(
    parameter int LOCK_CYC  = LOCK_CYCLES,
    parameter int SEC_TICKS = WATCH_SEC_TICKS
) (
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        IMO_CLK_IN,
    input  wire logic        XTAL_CLK_IN,
    input  wire logic        DSI_CLK_IN,
    input  wire logic        LSO_100K_IN,
    input  wire logic        LSO_1K_IN,
    input  wire logic        WATCH_CLK_IN,
    input  wire logic        HIBERNATE_IN,
    input  wire logic        DEBUG_HALT_IN,
    input  wire logic [7:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    output logic      [7:0]  DIG_CLK_OUT,
    output logic      [3:0]  ANA_CLK_OUT,
    output logic             BUS_CLK_OUT,
    output logic             CPU_CLK_OUT,
    output logic             USB_CLK_OUT,
    output logic             PLL_LOCK_OUT,
    output logic      [1:0]  IMO_FREQ_OUT,
    output logic             WATCH_LP_OUT,
    output logic             MASTER_LP_OUT,
    output logic             CTC_EVT_OUT,
    output logic             CTC_WAKE_OUT,
    output logic             FTC_EVT_OUT,
    output logic             SEC_EVT_OUT
);
    if (LOCK_CYC < 1 || LOCK_CYC > 65535 || SEC_TICKS < 2 || SEC_TICKS > 65535) begin : g_chk
        $error("csds_top: LOCK_CYC or SEC_TICKS out of range");
    end

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    wire  [7:0] async_w = {DEBUG_HALT_IN, HIBERNATE_IN, WATCH_CLK_IN, LSO_1K_IN,
                           LSO_100K_IN, DSI_CLK_IN, XTAL_CLK_IN, IMO_CLK_IN};
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] lvl_q;
    logic [7:0] rise_w;
    logic [7:0] fall_w;

    // three stages, a level counts once stages two and three agree
    for (genvar i = 0; i < 8; i++) begin : g_sync
        always_ff @(posedge CORE_CLK_IN) begin
            if (RST_IN) begin
                s1_q[i]  <= 1'b0;
                s2_q[i]  <= 1'b0;
                s3_q[i]  <= 1'b0;
                lvl_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= async_w[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    lvl_q[i] <= s3_q[i];
                end
            end
        end
        assign rise_w[i] = s2_q[i] & s3_q[i] & ~lvl_q[i];
        assign fall_w[i] = ~s2_q[i] & ~s3_q[i] & lvl_q[i];
    end

    wire imo_t   = rise_w[0];
    wire xtal_t  = rise_w[1];
    wire dsi_t   = rise_w[2];
    wire fast_t  = rise_w[3];
    wire slow_t  = rise_w[4];
    wire watch_t = rise_w[5];
    wire halt_w  = lvl_q[6] | lvl_q[7];

    // ****************************************************************
    // registers and avalon slave
    // ****************************************************************
    csds_ctrl_s ctrl_q;
    csds_pll_s  pll_q;
    logic [4:0]  fterm_q;
    logic [19:0] busdiv_q;
    csds_div_s   div_q [12];
    logic        wr_q;
    logic [12:0] ctc_q;
    logic [4:0]  ftc_q;
    logic        lock_q;

    wire [31:0] be_w   = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                          {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
    wire        req_w  = AVS_READ_IN | AVS_WRITE_IN;
    wire        wen_w  = AVS_WRITE_IN & ~wr_q;
    wire [31:0] wd_w   = AVS_WRITEDATA_IN & be_w;
    wire        div_a  = AVS_ADDRESS_IN >= OFS_DIV0 && AVS_ADDRESS_IN < OFS_DIV0 + 8'h30;
    wire [3:0]  div_ix = 4'((AVS_ADDRESS_IN - OFS_DIV0) >> 2);
    wire        ctc_clr = wen_w && AVS_ADDRESS_IN == OFS_CTRL && wd_w[14];
    wire [31:0] stat_w = (32'(lock_q) << STAT_LOCK_BIT) | (32'(ftc_q) << STAT_FTC_LSB)
                         | 32'(ctc_q);
    wire [31:0] rd_w   = (AVS_ADDRESS_IN == OFS_CTRL)   ? 32'(ctrl_q) & MSK_CTRL & ~32'h4000 :
                         (AVS_ADDRESS_IN == OFS_PLL)    ? 32'(pll_q) & MSK_PLL :
                         (AVS_ADDRESS_IN == OFS_STAT)   ? stat_w :
                         (AVS_ADDRESS_IN == OFS_FTC)    ? 32'(fterm_q) :
                         (AVS_ADDRESS_IN == OFS_BUSDIV) ? 32'(busdiv_q) :
                         (div_a && AVS_ADDRESS_IN[1:0] == 2'b00) ? 32'(div_q[div_ix]) & MSK_DIV :
                         32'h0000_0000;

    // waitrequest drops for one cycle after a request is seen
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            wr_q             <= 1'b1;
            AVS_READDATA_OUT <= 32'h0000_0000;
        end else begin
            wr_q <= ~(req_w & wr_q);
            if (AVS_READ_IN & wr_q) begin
                AVS_READDATA_OUT <= rd_w;
            end
        end
    end
    assign AVS_WAITREQUEST_OUT = wr_q;

    // register writes, merged per byte lane
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            ctrl_q   <= csds_ctrl_s'(RST_CTRL);
            pll_q    <= csds_pll_s'(RST_PLL);
            fterm_q  <= RST_FTC[4:0];
            busdiv_q <= RST_BUSDIV[19:0];
        end else if (wen_w) begin
            if (AVS_ADDRESS_IN == OFS_CTRL) begin
                ctrl_q <= csds_ctrl_s'((32'(ctrl_q) & ~be_w | wd_w) & MSK_CTRL & ~32'h4000);
            end
            if (AVS_ADDRESS_IN == OFS_PLL) begin
                pll_q <= csds_pll_s'((32'(pll_q) & ~be_w | wd_w) & MSK_PLL);
            end
            if (AVS_ADDRESS_IN == OFS_FTC) begin
                fterm_q <= AVS_BYTEENABLE_IN[0] ? wd_w[4:0] : fterm_q;
            end
            if (AVS_ADDRESS_IN == OFS_BUSDIV) begin
                busdiv_q <= 20'((32'(busdiv_q) & ~be_w | wd_w) & MSK_BUSDIV);
            end
        end
    end

    for (genvar i = 0; i < 12; i++) begin : g_dreg
        always_ff @(posedge CORE_CLK_IN) begin
            if (RST_IN) begin
                div_q[i] <= csds_div_s'(RST_DIV);
            end else if (wen_w && div_a && div_ix == 4'(i) && AVS_ADDRESS_IN[1:0] == 2'b00) begin
                div_q[i] <= csds_div_s'((32'(div_q[i]) & ~be_w | wd_w) & MSK_DIV);
            end
        end
    end

    // ****************************************************************
    // doubler and pll
    // ****************************************************************
    wire [3:0] ref_edge = {1'b0, dsi_t, xtal_t, imo_t};
    wire [3:0] ref_fall = {1'b0, fall_w[2], fall_w[1], fall_w[0]};
    // doubler ticks on both edges of its chosen input
    wire dbl_t = ref_edge[ctrl_q.dbl_src] | ref_fall[ctrl_q.dbl_src];
    wire pref_t = ref_edge[ctrl_q.pll_ref];

    csds_pll_e   pst_q;
    logic [15:0] lock_cnt_q;
    logic [15:0] per_cnt_q;
    logic [15:0] per_q;
    logic [23:0] acc_q;
    wire  [6:0]  in_div = 7'(pll_q.ind) + 7'd1;
    wire  [5:0]  fb_div = (pll_q.fb == 6'h00) ? 6'h01 : pll_q.fb;
    wire  [23:0] thr_w  = 24'(per_q) * 24'(in_div);
    wire  [23:0] acc_nx = acc_q + 24'(fb_div);
    // output period is reference period times in over feedback
    wire         pll_t  = ctrl_q.pll_en && per_q != 16'h0000 && acc_nx >= thr_w;

    // usb clock toggles on every doubler tick
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            USB_CLK_OUT <= 1'b0;
        end else if (dbl_t) begin
            USB_CLK_OUT <= ~USB_CLK_OUT;
        end
    end

    // reference period measure and rate generator
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN || !ctrl_q.pll_en) begin
            per_cnt_q <= 16'h0000;
            per_q     <= 16'h0000;
            acc_q     <= 24'h000000;
        end else begin
            per_cnt_q <= pref_t ? 16'h0001 : per_cnt_q + {15'h0000, ~&per_cnt_q};
            if (pref_t) begin
                per_q <= per_cnt_q;
            end
            acc_q <= pll_t ? acc_nx - thr_w : acc_nx;
        end
    end

    // lock after the lock time from enable
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            pst_q      <= PLL_OFF;
            lock_cnt_q <= 16'h0000;
        end else begin
            case (pst_q)
                PLL_OFF: begin
                    lock_cnt_q <= 16'h0000;
                    if (ctrl_q.pll_en) begin
                        pst_q <= PLL_ACQ;
                    end
                end
                PLL_ACQ: begin
                    lock_cnt_q <= lock_cnt_q + 16'h0001;
                    if (!ctrl_q.pll_en) begin
                        pst_q <= PLL_OFF;
                    end else if (lock_cnt_q == 16'(LOCK_CYC - 1)) begin
                        pst_q <= PLL_LCK;
                    end
                end
                PLL_LCK: begin
                    if (!ctrl_q.pll_en) begin
                        pst_q <= PLL_OFF;
                    end
                end
                default: pst_q <= PLL_OFF;
            endcase
        end
    end
    assign lock_q = (pst_q == PLL_LCK);

    // lock, oscillator settings and power modes driven out
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            PLL_LOCK_OUT  <= 1'b0;
            IMO_FREQ_OUT  <= 2'b00;
            WATCH_LP_OUT  <= 1'b0;
            MASTER_LP_OUT <= 1'b0;
        end else begin
            PLL_LOCK_OUT  <= lock_q;
            IMO_FREQ_OUT  <= ctrl_q.imo_freq;
            WATCH_LP_OUT  <= ctrl_q.watch_lp;
            MASTER_LP_OUT <= ctrl_q.master_lp;
        end
    end

    // ****************************************************************
    // low-speed clocks and tick counters
    // ****************************************************************
    logic [1:0]  third_q;
    logic [15:0] sec_q;
    wire third_t = fast_t && third_q == 2'(THIRD_DIV - 1);
    wire ctc_inc = slow_t && !halt_w;
    wire [12:0] ctc_nx = ctc_q + 13'h0001;
    wire ctc_ev  = ctc_inc && ctc_q[ctrl_q.ctc_tap] && !ctc_nx[ctrl_q.ctc_tap];
    wire ftc_tc  = fast_t && ftc_q == fterm_q;
    wire sec_tc  = watch_t && sec_q == 16'(SEC_TICKS - 1);

    // software restart has priority over counting
    // count frozen in hibernate or debug halt
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN || ctc_clr) begin
            ctc_q <= 13'h0000;
        end else if (ctc_inc) begin
            ctc_q <= ctc_nx;
        end
    end

    // fast count restarts at its terminal value
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            ftc_q   <= 5'h00;
            third_q <= 2'b00;
            sec_q   <= 16'h0000;
        end else begin
            if (fast_t) begin
                ftc_q   <= ftc_tc ? 5'h00 : ftc_q + 5'h01;
                third_q <= third_t ? 2'b00 : third_q + 2'b01;
            end
            if (watch_t) begin
                sec_q <= sec_tc ? 16'h0000 : sec_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            CTC_EVT_OUT  <= 1'b0;
            CTC_WAKE_OUT <= 1'b0;
            FTC_EVT_OUT  <= 1'b0;
            SEC_EVT_OUT  <= 1'b0;
        end else begin
            CTC_EVT_OUT  <= ctc_ev & ctrl_q.ctc_en & ~ctc_clr;
            CTC_WAKE_OUT <= ctc_ev & ~ctc_clr;
            FTC_EVT_OUT  <= ftc_tc & ctrl_q.ftc_en;
            SEC_EVT_OUT  <= sec_tc;
        end
    end

    // ****************************************************************
    // divider tree
    // ****************************************************************
    // main osc, crystal, interconnect, pll, doubler, fast, third-rate and watch ticks as sources
    wire [SRC_N-1:0] src_w = {watch_t, third_t, fast_t, dbl_t, pll_t, dsi_t, xtal_t, imo_t};
    // low-power master runs from the fast tick clock
    wire master_t = ctrl_q.master_lp ? fast_t : 1'b1;
    wire bus_rise;
    logic [11:0] dclk_w;

    for (genvar i = 0; i < 12; i++) begin : g_div
        csds_clkdiv #(.W(16)) u_div (
            .clk_in   (CORE_CLK_IN),
            .rst_in   (RST_IN),
            .tick_in  (src_w[div_q[i].src]),
            .div_in   (div_q[i].div),
            .clk_out  (dclk_w[i]),
            .rise_out ()
        );
    end
    assign DIG_CLK_OUT = dclk_w[7:0];
    assign ANA_CLK_OUT = dclk_w[11:8];

    // bus divider on the master clock
    csds_clkdiv #(.W(16)) u_bus (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RST_IN),
        .tick_in  (master_t),
        .div_in   (busdiv_q[15:0]),
        .clk_out  (BUS_CLK_OUT),
        .rise_out (bus_rise)
    );

    // processor divider fed by bus clock
    csds_clkdiv #(.W(4)) u_cpu (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RST_IN),
        .tick_in  (bus_rise),
        .div_in   (busdiv_q[19:16]),
        .clk_out  (CPU_CLK_OUT),
        .rise_out ()
    );

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_lock_off_clear: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        !ctrl_q.pll_en |=> ##1 !PLL_LOCK_OUT) else $error("lock shown while pll off");
    a_lock_after_time: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        $rose(lock_q) |-> $past(lock_cnt_q) == 16'(LOCK_CYC - 1)) else $error("early lock");
    a_ctc_frozen: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        halt_w && !ctc_clr |=> $stable(ctc_q)) else $error("tick counter moved in halt");
    a_ctc_counts: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        ctc_inc && !ctc_clr |=> ctc_q == $past(ctc_q) + 13'h0001) else $error("count miss");
    a_ctc_restart: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        ctc_clr |=> ctc_q == 13'h0000) else $error("tick counter not restarted");
    a_ftc_wrap_evt: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        ftc_tc && ctrl_q.ftc_en |=> FTC_EVT_OUT && ftc_q == 5'h00) else $error("fast tc");
    a_third_rate: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        third_t |-> fast_t && third_q == 2'b10) else $error("third rate tick wrong");
    a_usb_doubles: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        dbl_t |=> USB_CLK_OUT != $past(USB_CLK_OUT)) else $error("doubler missed edge");
endmodule

// ---- verification/csds_osc_model.sv ----
// behavioural model of the oscillators that feed the clock system
`timescale 1ns/100ps
module csds_osc_model (
    output logic imo_out,
    output logic xtal_out,
    output logic dsi_out,
    output logic lso_100k_out,
    output logic lso_1k_out,
    output logic watch_out
);
    // sources scaled so that each low-speed and watch tick spans ten or more core cycles
    initial begin
        imo_out      = 1'b0;
        xtal_out     = 1'b0;
        dsi_out      = 1'b0;
        lso_100k_out = 1'b0;
        lso_1k_out   = 1'b0;
        watch_out    = 1'b0;
    end
    // even half periods keep every source edge off the core clock's rising edges
    always #6 imo_out = ~imo_out;
    always #8 xtal_out = ~xtal_out;
    always #12 dsi_out = ~dsi_out;
    always #50 lso_100k_out = ~lso_100k_out; // one tick every 10 core cycles
    always #100 lso_1k_out = ~lso_1k_out;    // one tick every 20 core cycles
    always #50 watch_out = ~watch_out;       // one tick every 10 core cycles
endmodule

// ---- verification/tb.sv ----
// self-checking bench: registers, pll lock, tick counters and dividers
`timescale 1ns/100ps
module tb
    import csds_pkg::*;
;
    logic        clk, rst, hib, dbg, rd, wr, waitreq, lock, wlp, mlp, fevt, sevt;
    logic [7:0]  adr, dig;
    logic [31:0] wd, rdat, q;
    logic [3:0]  ana;
    logic [1:0]  internal_main_osc;
    logic [13:0] clks;
    logic        bus, cpu, cev, wak;
    logic        s_imo, s_xt, s_dsi, s_100k, s_1k, s_w;
    int          error_cnt, checks_done, sec_n, ftc_n, cev_n, wak_n, c, a, d, i;
    assign clks = {cpu, bus, ana, dig};
    csds_osc_model OSC (.imo_out(s_imo), .xtal_out(s_xt), .dsi_out(s_dsi),
        .lso_100k_out(s_100k), .lso_1k_out(s_1k), .watch_out(s_w));
    csds_top #(.LOCK_CYC(20), .SEC_TICKS(8)) DUT (.CORE_CLK_IN(clk), .RST_IN(rst),
        .IMO_CLK_IN(s_imo), .XTAL_CLK_IN(s_xt), .DSI_CLK_IN(s_dsi), .LSO_100K_IN(s_100k),
        .LSO_1K_IN(s_1k), .WATCH_CLK_IN(s_w), .HIBERNATE_IN(hib), .DEBUG_HALT_IN(dbg),
        .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
        .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(waitreq),
        .DIG_CLK_OUT(dig), .ANA_CLK_OUT(ana), .BUS_CLK_OUT(bus), .CPU_CLK_OUT(cpu),
        .USB_CLK_OUT(), .PLL_LOCK_OUT(lock), .IMO_FREQ_OUT(internal_main_osc), .WATCH_LP_OUT(wlp),
        .MASTER_LP_OUT(mlp), .CTC_EVT_OUT(cev), .CTC_WAKE_OUT(wak), .FTC_EVT_OUT(fevt),
        .SEC_EVT_OUT(sevt));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // event pulse counters
    always @(posedge clk) begin
        if (sevt === 1'b1) sec_n++;
        if (fevt === 1'b1) ftc_n++;
        if (cev === 1'b1) cev_n++;
        if (wak === 1'b1) wak_n++;
    end
    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= ad;
        wd <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (waitreq === 1'b0) break;
        end
        if (n == 20) begin
            error_cnt++;
            conclude();
        end
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // cycles to the next rising level of one divided clock
    task automatic rise(input int b);
        c = 0;
        while (clks[b] !== 1'b0 && c < 300) begin @(posedge clk); c++; end
        while (clks[b] !== 1'b1 && c < 300) begin @(posedge clk); c++; end
        if (c >= 300) begin
            error_cnt++;
            conclude();
        end
    endtask
    initial begin
        {rst, hib, dbg, rd, wr, adr, wd} = {1'b1, 44'h0};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        acc(0, OFS_CTRL, 0);   chk(q, RST_CTRL);
        acc(0, OFS_PLL, 0);    chk(q, RST_PLL);
        acc(0, OFS_FTC, 0);    chk(q, RST_FTC);
        // lower the terminal while the fast count is still below it
        acc(1, OFS_FTC, 3);
        acc(0, OFS_BUSDIV, 0); chk(q, RST_BUSDIV);
        acc(0, 8'h4c, 0);      chk(q, RST_DIV);
        // all-ones divisor only on an unmeasured divider, it reloads at period end
        acc(1, 8'h4c, 32'hffffffff);    acc(0, 8'h4c, 0);    chk(q, MSK_DIV);
        acc(1, OFS_PLL, 32'hffffffff);  acc(0, OFS_PLL, 0);  chk(q, MSK_PLL);
        acc(1, 8'hfc, 32'hffffffff);    acc(0, 8'hfc, 0);    chk(q, 32'h0);
        acc(1, OFS_PLL, RST_PLL);
        for (i = 0; i < 4; i++) begin
            acc(1, OFS_CTRL, 32'(i) | (32'(i % 2) << 7) | (32'(i / 2) << 8));
            repeat (2) @(posedge clk);
            chk({wlp, mlp, internal_main_osc}, {i[1], i[0], i[1:0]});
        end
        acc(1, OFS_CTRL, 32'h40);
        chk(lock, 0);
        for (c = 0; c < 60 && lock !== 1'b1; c++) @(posedge clk);
        chk(c >= 15 && c <= 25, 1);
        acc(0, OFS_STAT, 0); chk(q[STAT_LOCK_BIT], 1);
        acc(1, OFS_CTRL, 0);
        repeat (3) @(posedge clk);
        chk(lock, 0);
        acc(0, OFS_STAT, 0); chk(q[STAT_LOCK_BIT], 0);
        acc(1, OFS_CTRL, 32'h600);
        a = ftc_n;
        for (i = 0; i < 12; i++) begin
            repeat (7) @(posedge clk);
            acc(0, OFS_STAT, 0); chk(q[20:16] <= 3, 1);
        end
        chk(ftc_n - a >= 3, 1);
        a = sec_n;
        c = cev_n;
        d = wak_n;
        repeat (800) @(posedge clk);
        chk(sec_n - a >= 9 && sec_n - a <= 11, 1);
        chk(cev_n - c >= 19 && cev_n - c <= 21, 1);
        chk(wak_n - d >= 19 && wak_n - d <= 21, 1);
        acc(1, OFS_CTRL, 32'h4000);
        acc(0, OFS_STAT, 0); chk(q[12:0] <= 1, 1);
        for (i = 0; i < 2; i++) begin
            {dbg, hib} <= 2'(1 << i);
            repeat (10) @(posedge clk);
            acc(0, OFS_STAT, 0); a = q[12:0];
            repeat (50) @(posedge clk);
            acc(0, OFS_STAT, 0); chk(q[12:0], a);
            {dbg, hib} <= 2'b00;
            repeat (50) @(posedge clk);
            acc(0, OFS_STAT, 0); chk(q[12:0] !== a, 1);
        end
        acc(1, OFS_DIV0, 32'h00050004);
        acc(1, 8'h40, 32'h00070006);
        rise(0); rise(0); chk(c >= 37 && c <= 43, 1);
        rise(8); rise(8); chk(c >= 57 && c <= 63, 1);
        rise(12); rise(12); chk(c, 2);
        rise(13); rise(13); chk(c, 4);
        acc(1, OFS_CTRL, 32'h80);
        rise(12); rise(12); chk(c, 20);
        conclude();
    end
endmodule
